//--- src/pci_master_pkg.sv
// Shared constants and types of the master command port.
package pci_master_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_CMD      = 8'h10;
  localparam logic [7:0] OFF_BURST    = 8'h14;
  localparam logic [7:0] OFF_ADDR     = 8'h18;

  // Control register fields.
  localparam int CTRL_CLK_SEL   = 0;
  localparam int CTRL_FOUR_PORT = 1;

  // Status register fields.
  localparam int STAT_READY = 4;
  localparam int STAT_OCC_N = 5;
  localparam int STAT_ABORT = 6;
  localparam int STAT_REQ   = 7;

  // Interrupt status and mask bit positions.
  localparam int IRQ_ABORT   = 0;
  localparam int IRQ_DONE    = 1;
  localparam int IRQ_REFUSED = 2;

  // Values after reset.
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [3:0] SYNC_RST = 4'hF;

  // System cycles per PCI clock tick.
  localparam int PCI_DIV_DEF = 3;

  // Fields of a setup word.
  localparam int CMD_W     = 4;
  localparam int BURST_LSB = 8;
  localparam int BURST_W   = 8;

  // Setup sequence, shown to user logic as the state value.
  typedef enum logic [3:0] {
    ST_CMD    = 4'h1,
    ST_BURST  = 4'h2,
    ST_ADDR   = 4'h4,
    ST_QUEUED = 4'h8
  } setup_state_t;

  // Bus side protocol state.
  typedef enum logic [2:0] {
    P_IDLE = 3'h1,
    P_RUN  = 3'h2,
    P_HOLD = 3'h4
  } pci_state_t;

endpackage

//--- src/queue_if.sv
// Link between the core logic and the setup word sequencer.
interface queue_if;
  logic                        tick;      // Fabric clock tick.
  logic                        clear;     // Queue clear level.
  logic                        load;      // Setup strobe level.
  logic                        four_port; // Interface mode.
  logic                        ready;     // Interface usable.
  logic [31:0]                 word;      // Setup word.
  logic                        done;      // Transaction finished.
  pci_master_pkg::setup_state_t state;    // Sequence state.
  logic [3:0]                  cmd;       // Stored command.
  logic [7:0]                  burst;     // Stored burst length.
  logic [31:0]                 addr;      // Stored start address.
  logic                        queued;    // Address register occupied.
  logic                        is_read;   // Stored command reads.
  logic                        refused;   // Strobe refused pulse.
  logic                        taken;     // Command word taken pulse.

  modport seq (input tick, clear, load, four_port, ready, word, done,
               output state, cmd, burst, addr, queued, is_read, refused, taken);
  modport core (output tick, clear, load, four_port, ready, word, done,
                input state, cmd, burst, addr, queued, is_read, refused, taken);
endinterface

//--- src/pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
module pin_sync #(
  parameter int               WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT  = '1
) (
  // Clock and reset.
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // Raw pins and filtered levels.
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic s1_ff;     // Only read by the second stage.
      logic s2_ff;     // Second stage.
      logic s3_ff;     // Third stage.
      logic lvl_ff;    // Accepted level.
      logic nxt_lvl;   // Next accepted level.

      // A change counts only when the last two stages agree.
      always_comb
      begin
        nxt_lvl = (s2_ff == s3_ff) ? s2_ff : lvl_ff;
      end

      // Shift the pin through the stages.
      always_ff @(posedge clk_sys_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          s1_ff  <= INIT[i];
          s2_ff  <= INIT[i];
          s3_ff  <= INIT[i];
          lvl_ff <= INIT[i];
        end
        else
        begin
          s1_ff  <= pin_in[i];
          s2_ff  <= s1_ff;
          s3_ff  <= s2_ff;
          lvl_ff <= nxt_lvl;
        end
      end

      assign level_out[i] = lvl_ff;
    end
  endgenerate

endmodule // pin_sync

//--- src/setup_sequencer.sv
// Loads command, burst length and start address words in order; a separate burst word comes only in four-port reads.
module setup_sequencer (
  // Clock and reset.
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // Link to the core logic.
  queue_if.seq      q
);

  pci_master_pkg::setup_state_t state_ff, nxt_state;  // Sequence state.
  logic [3:0]  cmd_ff, nxt_cmd;                        // Command.
  logic [7:0]  burst_ff, nxt_burst;                    // Burst length.
  logic [31:0] addr_ff, nxt_addr;                      // Start address.
  logic        ref_ff, nxt_ref;                        // Refused pulse.
  logic        take_ff, nxt_take;                      // Taken pulse.

  // Decide the next word slot from the state and the mode.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cmd   = cmd_ff;
    nxt_burst = burst_ff;
    nxt_addr  = addr_ff;
    nxt_ref   = 1'b0;
    nxt_take  = 1'b0;
    if (q.clear)
    begin
      // Clearing empties the queue and restarts the state value. [RL5]
      nxt_state = pci_master_pkg::ST_CMD;
      nxt_cmd   = 4'h0;
      nxt_burst = 8'h00;
      nxt_addr  = 32'h0000_0000;
    end
    else if (q.done && (state_ff == pci_master_pkg::ST_QUEUED))
    begin
      nxt_state = pci_master_pkg::ST_CMD;
    end
    else if (q.tick && q.load)
    begin
      if (!q.ready || (state_ff == pci_master_pkg::ST_QUEUED))
      begin
        // An occupied register or an unready port takes nothing. [RL9] [RL13]
        nxt_ref = 1'b1;
      end
      else
      begin
        // Each strobe stores one word in the slot the state names. [RL8]
        case (state_ff)
          pci_master_pkg::ST_CMD:
          begin
            nxt_cmd  = q.word[pci_master_pkg::CMD_W-1:0];
            nxt_take = 1'b1;
            if (!q.four_port)
            begin
              // Two-port mode packs the burst length with the command.
              nxt_burst = q.word[pci_master_pkg::BURST_LSB +: pci_master_pkg::BURST_W];
              nxt_state = pci_master_pkg::ST_ADDR;
            end
            else if (!q.word[0])
            begin
              nxt_state = pci_master_pkg::ST_BURST;
            end
            else
            begin
              nxt_state = pci_master_pkg::ST_ADDR;
            end
          end
          pci_master_pkg::ST_BURST:
          begin
            nxt_burst = q.word[pci_master_pkg::BURST_W-1:0];
            nxt_state = pci_master_pkg::ST_ADDR;
          end
          pci_master_pkg::ST_ADDR:
          begin
            nxt_addr  = q.word;
            nxt_state = pci_master_pkg::ST_QUEUED;
          end
          default:
          begin
            nxt_state = pci_master_pkg::ST_CMD;
          end
        endcase
      end
    end
  end

  // Register the sequence.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= pci_master_pkg::ST_CMD;
      cmd_ff   <= 4'h0;
      burst_ff <= 8'h00;
      addr_ff  <= 32'h0000_0000;
      ref_ff   <= 1'b0;
      take_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cmd_ff   <= nxt_cmd;
      burst_ff <= nxt_burst;
      addr_ff  <= nxt_addr;
      ref_ff   <= nxt_ref;
      take_ff  <= nxt_take;
    end
  end

  // The state value is shown straight from its flip-flops. [RL4]
  assign q.state   = state_ff;
  assign q.cmd     = cmd_ff;
  assign q.burst   = burst_ff;
  assign q.addr    = addr_ff;
  assign q.queued  = (state_ff == pci_master_pkg::ST_QUEUED);
  assign q.is_read = ~cmd_ff[0];
  assign q.refused = ref_ff;
  assign q.taken   = take_ff;

endmodule // setup_sequencer

//--- src/pci_master_cmd_port.sv
// Master command port between the PCI core and user fabric logic.
//
// How it works
// [RL1] Hold input keeps bus request until release or disconnect.
// [RL2] User holds the hold input two PCI ticks.
// [RL3] Target abort raises the cycle-aborted indication.
// [RL4] Four-bit state value shows the setup sequence.
// [RL5] Queue clear empties queues, resets the state value.
// [RL6] Queue clear leaves the bus protocol running.
// [RL7] Ready high only when usable; low in resets.
// [RL8] Each setup strobe loads one word by state.
// [RL9] Occupied flag set; new transactions refused meanwhile.
// [RL10] Writes free the register after all data sent.
// [RL11] Reads free it once all data has arrived.
// [RL12] Fabric-side logic steps on a selectable fabric clock.
// [RL13] User never strobes while occupied or not ready.
module pci_master_cmd_port #(
  parameter int PCI_DIV = pci_master_pkg::PCI_DIV_DEF
) (
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Register port.
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  output logic             irq_out,
  // Fabric pins from the user logic.
  input  wire logic        fabric_clock_a_in,
  input  wire logic        fabric_clock_b_in,
  input  wire logic        master_queue_clear_n_in,
  input  wire logic        master_hold_n_in,
  input  wire logic        setup_strobe_n_in,
  input  wire logic [31:0] setup_word_in,
  // Indications toward the user logic.
  output logic             master_addr_reg_occupied_n_out,
  output logic             cycle_aborted_out,
  output logic [3:0]       master_state_out,
  output logic             master_ready_out,
  // Bus protocol engine.
  input  wire logic        pci_reset_in,
  input  wire logic        target_abort_in,
  input  wire logic        target_disconnect_in,
  input  wire logic        write_data_sent_in,
  input  wire logic        read_data_received_in,
  output logic             bus_request_out
);

  localparam int DIV_W = $clog2(PCI_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PCI_DIV - 1);

  queue_if q ();

  logic [3:0] pins_lvl;  // Filtered clock a, clock b, queue clear_n and hold_n, high to low.

  // Pins from the fabric cross into this domain through three stages.
  pin_sync #(
    .WIDTH (4),
    .INIT  (pci_master_pkg::SYNC_RST)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .pin_in     ({fabric_clock_a_in, fabric_clock_b_in,
                  master_queue_clear_n_in, master_hold_n_in}),
    .level_out  (pins_lvl)
  );


  // The strobe takes the three stages of the clock pins and the word two, so they line up.
  logic        stb_s1_ff, stb_s2_ff, stb_s3_ff;  // Strobe stages.
  logic [31:0] word_s1_ff, word_s2_ff;           // Word stages.

  // Delay strobe and word to match the filtered fabric clock.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stb_s1_ff  <= 1'b1;
      stb_s2_ff  <= 1'b1;
      stb_s3_ff  <= 1'b1;
      word_s1_ff <= 32'h0000_0000;
      word_s2_ff <= 32'h0000_0000;
    end
    else
    begin
      stb_s1_ff  <= setup_strobe_n_in;
      stb_s2_ff  <= stb_s1_ff;
      stb_s3_ff  <= stb_s2_ff;
      word_s1_ff <= setup_word_in;
      word_s2_ff <= word_s1_ff;
    end
  end

  logic [1:0] ctrl_ff, nxt_ctrl;  // Clock select and port mode.
  logic       fab_prev_ff;        // Selected fabric clock, last cycle.
  logic       fab_sel;            // Selected fabric clock level.
  logic       fab_tick;           // Fabric rising edge pulse.

  // Only the selected fabric clock paces the setup logic. [RL12]
  always_comb
  begin
    fab_sel  = ctrl_ff[pci_master_pkg::CTRL_CLK_SEL] ? pins_lvl[2] : pins_lvl[3];
    fab_tick = fab_sel & ~fab_prev_ff;
  end

  logic [DIV_W-1:0] div_ff, nxt_div;  // PCI tick divider.
  logic             pci_tick;         // One PCI clock period elapsed.

  // The hold input is a PCI clock signal, paced by the divider.
  always_comb
  begin
    pci_tick = (div_ff == DIV_LAST);
    nxt_div  = pci_tick ? '0 : div_ff + 1'b1;
  end

  // Tie the sequencer to the synchronised user signals.
  assign q.tick      = fab_tick;
  assign q.clear     = ~pins_lvl[1];
  assign q.load      = ~stb_s3_ff;
  assign q.four_port = ctrl_ff[pci_master_pkg::CTRL_FOUR_PORT];
  assign q.ready     = master_ready_out;
  assign q.word      = word_s2_ff;

  setup_sequencer u_seq (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .q          (q)
  );

  pci_master_pkg::pci_state_t pst_ff, nxt_pst;  // Bus side state.
  logic hold_ff, nxt_hold;        // Hold seen at a PCI tick.
  logic finish;                   // All data moved for the job.
  logic run_rd_ff, nxt_run_rd;    // Running job is a read.
  logic done;                     // Bus job ended.
  logic abort_ev;                 // Abort seen on a running job.

  // A write ends when its data is out, a read when its data is in.
  always_comb
  begin
    finish   = run_rd_ff ? read_data_received_in  // [RL11]
                         : write_data_sent_in;    // [RL10]
    abort_ev = (pst_ff == pci_master_pkg::P_RUN) && target_abort_in;
    done     = (pst_ff == pci_master_pkg::P_RUN) && (finish || target_abort_in);
    nxt_hold = pci_tick ? ~pins_lvl[0] : hold_ff;  // [RL2]
    // The direction is caught on entering RUN, so a queue clear cannot flip it. [RL6]
    nxt_run_rd = (pst_ff == pci_master_pkg::P_RUN) ? run_rd_ff : q.is_read;
  end

  // Bus state; the queue clear has no say here. [RL6]
  always_comb
  begin
    nxt_pst = pst_ff;
    if (pci_reset_in)
    begin
      nxt_pst = pci_master_pkg::P_IDLE;
    end
    else
    begin
      case (pst_ff)
        pci_master_pkg::P_IDLE:
        begin
          if (q.queued)
          begin
            nxt_pst = pci_master_pkg::P_RUN;
          end
        end
        pci_master_pkg::P_RUN:
        begin
          if (done)
          begin
            // A held bus stays requested after the job. [RL1]
            nxt_pst = (hold_ff && !target_disconnect_in) ? pci_master_pkg::P_HOLD
                                                         : pci_master_pkg::P_IDLE;
          end
        end
        pci_master_pkg::P_HOLD:
        begin
          if (!hold_ff || target_disconnect_in)
          begin
            // Release or disconnect drops the held request. [RL1]
            nxt_pst = pci_master_pkg::P_IDLE;
          end
          else if (q.queued)
          begin
            nxt_pst = pci_master_pkg::P_RUN;
          end
        end
        default:
        begin
          nxt_pst = pci_master_pkg::P_IDLE;
        end
      endcase
    end
  end

  assign q.done = done;

  logic abort_ff, nxt_abort;  // Cycle aborted indication.
  logic ready_ff, nxt_ready;  // Port ready indication.
  logic occ_n_ff, nxt_occ_n;  // Address register occupied, low active.
  logic req_ff, nxt_req;      // Bus request.

  // Indications toward the user logic.
  always_comb
  begin
    // Abort stays until the next command word or a queue clear; a new abort wins. [RL3]
    nxt_abort = abort_ev | (abort_ff & ~q.taken & ~q.clear);
    // Ready falls during bus resets and queue clears. [RL7]
    nxt_ready = ~pci_reset_in & pins_lvl[1];
    // Occupied follows the sequencer, cleared by the job's end. [RL9]
    nxt_occ_n = ~q.queued;
    nxt_req   = (nxt_pst != pci_master_pkg::P_IDLE);  // [RL1]
  end

  logic [2:0]  ist_ff, nxt_ist;    // Sticky interrupt status.
  logic [2:0]  mask_ff, nxt_mask;  // Interrupt mask.
  logic        irq_ff, nxt_irq;    // Interrupt output.
  logic [31:0] rd_ff, nxt_rd;      // Read data.
  logic [2:0]  events;             // Event pulses.

  // Register writes and the read-clear interrupt status.
  always_comb
  begin
    events[pci_master_pkg::IRQ_ABORT]   = abort_ev;
    events[pci_master_pkg::IRQ_DONE]    = done;
    events[pci_master_pkg::IRQ_REFUSED] = q.refused;
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    if (reg_write_in && (reg_addr_in == pci_master_pkg::OFF_CTRL))
    begin
      nxt_ctrl = reg_wdata_in[1:0];
    end
    if (reg_write_in && (reg_addr_in == pci_master_pkg::OFF_IRQ_MASK))
    begin
      nxt_mask = reg_wdata_in[2:0];
    end
    // A read clears the status, but an event in that cycle still sets it.
    nxt_ist = ist_ff;
    if (reg_read_in && (reg_addr_in == pci_master_pkg::OFF_IRQ_STAT))
    begin
      nxt_ist = 3'h0;
    end
    nxt_ist = nxt_ist | events;
    nxt_irq = |(nxt_ist & nxt_mask);
  end

  // Read mux; unmapped offsets and idle cycles give zero.
  always_comb
  begin
    nxt_rd = 32'h0000_0000;
    if (reg_read_in)
    begin
      case (reg_addr_in)
        pci_master_pkg::OFF_CTRL:     nxt_rd[1:0] = ctrl_ff;
        pci_master_pkg::OFF_STATUS:
        begin
          nxt_rd[3:0] = q.state;
          nxt_rd[pci_master_pkg::STAT_READY] = ready_ff;
          nxt_rd[pci_master_pkg::STAT_OCC_N] = occ_n_ff;
          nxt_rd[pci_master_pkg::STAT_ABORT] = abort_ff;
          nxt_rd[pci_master_pkg::STAT_REQ]   = req_ff;
        end
        pci_master_pkg::OFF_IRQ_STAT: nxt_rd[2:0] = ist_ff;
        pci_master_pkg::OFF_IRQ_MASK: nxt_rd[2:0] = mask_ff;
        pci_master_pkg::OFF_CMD:      nxt_rd[3:0] = q.cmd;
        pci_master_pkg::OFF_BURST:    nxt_rd[7:0] = q.burst;
        pci_master_pkg::OFF_ADDR:     nxt_rd      = q.addr;
        default:                      nxt_rd      = 32'h0000_0000;
      endcase
    end
  end

  // Register every piece of state computed above.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_ff     <= pci_master_pkg::CTRL_RST;
      fab_prev_ff <= 1'b1;
      div_ff      <= '0;
      pst_ff      <= pci_master_pkg::P_IDLE;
      hold_ff     <= 1'b0;
      run_rd_ff   <= 1'b0;
      abort_ff    <= 1'b0;
      ready_ff    <= 1'b0;
      occ_n_ff    <= 1'b1;
      req_ff      <= 1'b0;
      ist_ff      <= 3'h0;
      mask_ff     <= pci_master_pkg::MASK_RST;
      irq_ff      <= 1'b0;
      rd_ff       <= 32'h0000_0000;
    end
    else
    begin
      ctrl_ff     <= nxt_ctrl;
      fab_prev_ff <= fab_sel;
      div_ff      <= nxt_div;
      pst_ff      <= nxt_pst;
      hold_ff     <= nxt_hold;
      run_rd_ff   <= nxt_run_rd;
      abort_ff    <= nxt_abort;
      ready_ff    <= nxt_ready;
      occ_n_ff    <= nxt_occ_n;
      req_ff      <= nxt_req;
      ist_ff      <= nxt_ist;
      mask_ff     <= nxt_mask;
      irq_ff      <= nxt_irq;
      rd_ff       <= nxt_rd;
    end
  end

  // Every output comes straight from a flip-flop.
  assign reg_rdata_out                  = rd_ff;
  assign irq_out                        = irq_ff;
  assign master_addr_reg_occupied_n_out = occ_n_ff;
  assign cycle_aborted_out              = abort_ff;
  assign master_state_out               = q.state;  // [RL4]
  assign master_ready_out               = ready_ff;
  assign bus_request_out                = req_ff;

endmodule // pci_master_cmd_port

//--- verif/pci_master_cmd_port_props.sv
// Concurrent checks on the pins of the master command port.
module pci_master_cmd_port_props #(
  parameter int PCI_DIV = pci_master_pkg::PCI_DIV_DEF
) (
  // Clock and reset.
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  // Register port and pins.
  input wire logic        reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        master_queue_clear_n_in,
  input wire logic        master_addr_reg_occupied_n_out,
  input wire logic        cycle_aborted_out,
  input wire logic [3:0]  master_state_out,
  input wire logic        master_ready_out,
  input wire logic        pci_reset_in,
  input wire logic        target_abort_in,
  input wire logic        write_data_sent_in,
  input wire logic        read_data_received_in,
  input wire logic        bus_request_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // System clock; quiet in reset.
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // Pulses that may end a job.
  wire logic ev = write_data_sent_in | read_data_received_in | target_abort_in;

  chk_ready_bus_reset: assert property (pci_reset_in |-> ##1 !master_ready_out)
    else $error("ready in bus reset");
  chk_req_bus_reset: assert property (pci_reset_in |-> ##1 !bus_request_out)
    else $error("request in bus reset");
  chk_state_one_hot: assert property ($onehot(master_state_out))
    else $error("state value not one-hot");
  chk_occ_when_queued: assert property ($fell(master_addr_reg_occupied_n_out)
    |-> $past(master_state_out) == 4'h8)
    else $error("occupied unqueued");
  chk_occ_free_end: assert property ($rose(master_addr_reg_occupied_n_out)
    |-> $past(ev, 2) || $past(ev, 3) || !master_ready_out)
    else $error("occupied freed early");
  chk_abort_cause: assert property ($rose(cycle_aborted_out)
    |-> $past(target_abort_in) || $past(target_abort_in, 2))
    else $error("abort without cause");
  chk_clear_empties: assert property (!master_queue_clear_n_in [*8] |-> !master_ready_out
    && master_state_out == 4'h1 && master_addr_reg_occupied_n_out)
    else $error("queue clear not applied");
  chk_req_after_queue: assert property ($rose(bus_request_out)
    |-> $past(master_state_out) == 4'h8)
    else $error("request unqueued");
  chk_rdata_idle_zero: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("stray read data");
  // Main scenarios.
  cov_abort: cover property ($rose(cycle_aborted_out));
  cov_request: cover property ($rose(bus_request_out));
  cov_occupied: cover property ($fell(master_addr_reg_occupied_n_out));
endmodule // pci_master_cmd_port_props

//--- verif/fabric_user_model.sv
// User fabric logic: free fabric clocks and the setup strobe driver.
module fabric_user_model (
  // Clock and reset.
  input  wire logic   clk_sys_in,
  input  wire logic   rst_in,
  // Pins toward the core.
  output logic        fab_a_out,
  output logic        fab_b_out,
  output logic        strobe_n_out,
  output logic [31:0] word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_ff; // Divider making both fabric clocks.
  // The two fabric clocks run free at different rates, periods 8 and 16.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in) cnt_ff <= 4'h0;
    else cnt_ff <= cnt_ff + 4'h1;
  end
  assign fab_a_out = cnt_ff[2];
  assign fab_b_out = cnt_ff[3];
  initial
  begin
    strobe_n_out = 1'b1;
    word_out = 32'h0000_0000;
  end
  // One word per strobe, held one fabric period, then inverted so it never looks valid.
  task automatic send(input logic b, input logic [31:0] w);
    @(posedge (b ? fab_b_out : fab_a_out));
    strobe_n_out <= 1'b0;
    word_out <= w;
    @(posedge (b ? fab_b_out : fab_a_out));
    strobe_n_out <= 1'b1;
    word_out <= ~w;
  endtask
endmodule // fabric_user_model

//--- verif/pci_master_command_fifo_port_tb_top.sv
// Self-checking bench of the master command port.
module pci_master_command_fifo_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PCI_DIV = 2; // Short PCI tick keeps hold phases brief.
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, setup_word_in;
  logic [3:0]  master_state_out;
  logic        clk_sys_in, rst_in, reg_write_in, reg_read_in, irq_out;
  logic        fabric_clock_a_in, fabric_clock_b_in, master_queue_clear_n_in;
  logic        master_hold_n_in, setup_strobe_n_in, master_addr_reg_occupied_n_out;
  logic        cycle_aborted_out, master_ready_out, pci_reset_in, target_abort_in;
  logic        target_disconnect_in, write_data_sent_in, read_data_received_in;
  logic        bus_request_out;
  int          errors, checks;
  logic [3:0]  ev; // Bus engine pulses: sent, received, abort, disconnect.
  wire logic   occ_n = master_addr_reg_occupied_n_out; // Occupied flag, low active.
  assign {write_data_sent_in, read_data_received_in, target_abort_in, target_disconnect_in} = ev;
  pci_master_cmd_port #(.PCI_DIV(PCI_DIV)) pci_master_cmd_port_i (.*);
  fabric_user_model fabric_user_model_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .fab_a_out(fabric_clock_a_in), .fab_b_out(fabric_clock_b_in),
    .strobe_n_out(setup_strobe_n_in), .word_out(setup_word_in));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  task automatic finish_test();
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    cyc(1);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_write_in <= 1'b1;
    cyc(1);
    reg_write_in <= 1'b0;
  endtask
  // Read data is compared in the one cycle it stands.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    cyc(1);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    cyc(1);
    reg_read_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
  endtask
  task automatic wait_st(input logic [3:0] s);
    for (int i = 0; i < 60 && master_state_out !== s; i++) cyc(1);
    chk(master_state_out, s);
  endtask
  // Pulse one bus engine event: 0 sent, 1 received, 2 abort, 3 disconnect.
  task automatic end_job(input int k);
    cyc(1);
    ev <= 4'h8 >> k;
    cyc(1);
    ev <= 4'h0;
    cyc(3);
    #1;
  endtask
  // Queue a whole job; the burst word only for reads on fabric clock a (b low).
  task automatic job(input logic b, input logic [31:0] c, bu, a);
    for (int i = 0; i < 60 && master_ready_out !== 1'b1; i++) cyc(1);
    fabric_user_model_i.send(b, c);
    if (!b && !c[0])
    begin
      wait_st(4'h2);
      fabric_user_model_i.send(b, bu);
    end
    wait_st(4'h4);
    fabric_user_model_i.send(b, a);
    wait_st(4'h8);
    cyc(3);
    #1 chk(occ_n, 1'b0);
    chk(bus_request_out, 1'b1);
  endtask
  task automatic qclear();
    master_queue_clear_n_in <= 1'b0;
    cyc(10);
    #1 chk(master_ready_out, 1'b0);
    chk(master_state_out, 4'h1);
    master_queue_clear_n_in <= 1'b1;
    cyc(10);
  endtask
  initial
  begin
    errors = 0;
    checks = 0;
    rst_in = 1'b1;
    {reg_addr_in, reg_wdata_in, reg_write_in, reg_read_in} = '0;
    {master_queue_clear_n_in, master_hold_n_in} = 2'h3;
    pci_reset_in = 1'b0;
    ev = 4'h0;
    cyc(8);
    rst_in <= 1'b0;
    cyc(8);
    rd(pci_master_pkg::OFF_CTRL, 32'h0000_0002);
    rd(pci_master_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    rd(pci_master_pkg::OFF_STATUS, 32'h0000_0031);
    rd(8'h40, 32'h0000_0000);
    wr(pci_master_pkg::OFF_IRQ_MASK, 32'h0000_0007);
    // Write job; a strobe while occupied is refused.
    job(1'b0, 32'h0000_0007, 32'h0, 32'h1234_5678);
    rd(pci_master_pkg::OFF_CMD, 32'h0000_0007);
    rd(pci_master_pkg::OFF_ADDR, 32'h1234_5678);
    fabric_user_model_i.send(1'b0, 32'h0000_0003);
    cyc(8);
    #1 chk(irq_out, 1'b1);
    rd(pci_master_pkg::OFF_IRQ_STAT, 32'h0000_0004);
    end_job(1); chk(occ_n, 1'b0);
    end_job(0); chk(occ_n, 1'b1);
    chk(bus_request_out, 1'b0);
    rd(pci_master_pkg::OFF_IRQ_STAT, 32'h0000_0002);
    rd(pci_master_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    chk(irq_out, 1'b0);
    // Read job with burst word.
    job(1'b0, 32'h0000_0006, 32'h0000_0010, 32'hA000_0000);
    rd(pci_master_pkg::OFF_BURST, 32'h0000_0010);
    end_job(0); chk(occ_n, 1'b0);
    end_job(1); chk(occ_n, 1'b1);
    // Abort, then the next command word drops the indication.
    job(1'b0, 32'h0000_0007, 32'h0, 32'h0000_0100);
    end_job(2); chk(cycle_aborted_out, 1'b1);
    rd(pci_master_pkg::OFF_IRQ_STAT, 32'h0000_0003);
    fabric_user_model_i.send(1'b0, 32'h0000_0007);
    wait_st(4'h4);
    chk(cycle_aborted_out, 1'b0);
    qclear();
    // Hold the request; a clear must not stop the running job.
    master_hold_n_in <= 1'b0;
    job(1'b0, 32'h0000_0007, 32'h0, 32'h0000_0200);
    qclear();
    chk(occ_n, 1'b1);
    chk(bus_request_out, 1'b1);
    end_job(0); chk(bus_request_out, 1'b1);
    end_job(3); chk(bus_request_out, 1'b0);
    master_hold_n_in <= 1'b1;
    pci_reset_in <= 1'b1;
    cyc(3);
    #1 chk(master_ready_out, 1'b0);
    pci_reset_in <= 1'b0;
    // Second fabric clock with two-port packing.
    wr(pci_master_pkg::OFF_CTRL, 32'h0000_0001);
    job(1'b1, 32'h0000_2006, 32'h0, 32'h0000_3000);
    rd(pci_master_pkg::OFF_BURST, 32'h0000_0020);
    end_job(1); chk(occ_n, 1'b1);
    finish_test();
  end
  // Watchdog, far beyond the run.
  initial
  begin
    cyc(30000);
    errors++;
    finish_test();
  end
endmodule // pci_master_command_fifo_port_tb_top
bind pci_master_cmd_port pci_master_cmd_port_props #(.PCI_DIV(PCI_DIV)) props_i (.*);
